// >>> hdl/rxwa_top.sv
// Purpose: Receive word aligner with manual and bit-slip modes, AHB-Lite registers
// Assumes: rx_word_i is on clk_i; align/slip requests arrive from another domain
`include "rxwa_params.svh"
`timescale 1ns/100ps
`default_nettype none

module rxwa_top
  import rxwa_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [9:0]  rx_word_i,
  input  wire logic        align_en_i,
  input  wire logic        slip_req_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [9:0]  rx_data_o,
  output logic             sync_status_o,
  output logic             pattern_hit_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Join three words, oldest in the low bits: stream is LSB first
  function automatic logic [29:0] f_stream(input logic       w10,
                                           input logic [9:0] n,
                                           input logic [9:0] m,
                                           input logic [9:0] o);
    if (w10) begin
      f_stream = {n, m, o};
    end else begin
      f_stream = {6'h00, n[7:0], m[7:0], o[7:0]};
    end
  endfunction : f_stream

  // Pattern test at bit offset; pattern's top word sits at k+W
  function automatic logic f_match(input logic        w10,
                                   input logic        len7,
                                   input logic [15:0] pat,
                                   input logic [29:0] strm,
                                   input logic [4:0]  k);
    logic [29:0] sh;
    sh = '0;
    if (w10) begin
      sh = strm >> (k + `RXWA_W10);
      if (len7) begin
        f_match = (sh[6:0] == pat[6:0]) || (sh[6:0] == ~pat[6:0]);
      end else begin
        f_match = (sh[9:0] == pat[9:0]) || (sh[9:0] == ~pat[9:0]);
      end
    end else begin
      sh = strm >> k;
      f_match = (sh[15:0] == pat);
    end
  endfunction : f_match

  // Output word at a boundary; larger boundary pulls newer bits in at MSB
  function automatic logic [9:0] f_word(input logic        w10,
                                        input logic [29:0] strm,
                                        input logic [4:0]  k);
    logic [29:0] sh;
    sh = '0;
    if (w10) begin
      sh = strm >> (k + `RXWA_W10);
      f_word = sh[9:0];
    end else begin
      sh = strm >> (k + `RXWA_W8);
      f_word = {2'h0, sh[7:0]};
    end
  endfunction : f_word

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rxwa_ctrl_t  ctrl_ff;
  logic [15:0] pat_ff;
  rxwa_stat_t  sticky_ff;
  rxwa_stat_t  mask_ff;
  rxwa_stat_t  nxt_sticky;
  rxwa_stat_t  nxt_stat;
  rxwa_arm_t   arm_ff;
  rxwa_arm_t   nxt_arm;
  logic [9:0]  w0_ff;
  logic [9:0]  w1_ff;
  logic [9:0]  w2_ff;
  logic [4:0]  bnd_ff;
  logic [4:0]  nxt_bnd;
  logic [2:0]  en_sync_ff;
  logic [2:0]  slip_sync_ff;
  logic        en_filt_ff;
  logic        slip_filt_ff;
  logic        en_rise;
  logic        slip_rise;
  logic [29:0] strm;
  logic [4:0]  width;
  logic [4:0]  found_k;
  logic        found;
  logic        hit_cur;
  logic        ph_act_ff;
  logic        ph_write_ff;
  logic [7:0]  ph_addr_ff;
  logic        addr_take;
  logic        rd_status;

  // ----------------------------------------------------------------
  // Request synchronisers and edge detect
  // ----------------------------------------------------------------

  // Three stages; filtered level moves only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_sync_ff   <= 3'h0;
      slip_sync_ff <= 3'h0;
      en_filt_ff   <= 1'b0;
      slip_filt_ff <= 1'b0;
    end else begin
      en_sync_ff   <= {en_sync_ff[1:0], align_en_i};
      slip_sync_ff <= {slip_sync_ff[1:0], slip_req_i};
      if (en_sync_ff[1] == en_sync_ff[2]) begin
        en_filt_ff <= en_sync_ff[2];
      end
      if (slip_sync_ff[1] == slip_sync_ff[2]) begin
        slip_filt_ff <= slip_sync_ff[2];
      end
    end
  end

  // Edge compares against previous filtered sample
  assign en_rise   = (en_sync_ff[1] == en_sync_ff[2]) && en_sync_ff[2] && !en_filt_ff;
  assign slip_rise = (slip_sync_ff[1] == slip_sync_ff[2]) && slip_sync_ff[2]
                     && !slip_filt_ff;

  // ----------------------------------------------------------------
  // Word history
  // ----------------------------------------------------------------

  // Three words cover a 16-bit pattern at any of eight offsets
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w0_ff <= 10'h000;
      w1_ff <= 10'h000;
      w2_ff <= 10'h000;
    end else begin
      w0_ff <= rx_word_i;
      w1_ff <= w0_ff;
      w2_ff <= w1_ff;
    end
  end

  assign strm  = f_stream(ctrl_ff.width10, w0_ff, w1_ff, w2_ff);
  assign width = ctrl_ff.width10 ? `RXWA_W10 : `RXWA_W8;

  // ----------------------------------------------------------------
  // Pattern search
  // ----------------------------------------------------------------

  // Lowest matching offset wins when several match
  always_comb begin
    found   = 1'b0;
    found_k = 5'h00;
    for (int i = 9; i >= 0; i--) begin
      if ((5'(i) < width) && f_match(ctrl_ff.width10, ctrl_ff.len7, pat_ff, strm, 5'(i))) begin
        found   = 1'b1;
        found_k = 5'(i);
      end
    end
  end

  assign hit_cur = f_match(ctrl_ff.width10, ctrl_ff.len7, pat_ff, strm, bnd_ff);

  // ----------------------------------------------------------------
  // Boundary control
  // ----------------------------------------------------------------

  // Current boundary is preferred so a steady stream never re-aligns
  always_comb begin
    nxt_bnd  = bnd_ff;
    nxt_arm  = arm_ff;
    nxt_stat = '0;
    if (ctrl_ff.slip_mode) begin
      if (slip_rise) begin
        nxt_bnd = (bnd_ff + 5'h01 >= width) ? 5'h00 : bnd_ff + 5'h01;
      end else begin
        nxt_stat.hit = hit_cur;
      end
    end else if (ctrl_ff.width10) begin
      if (hit_cur) begin
        nxt_stat.hit = 1'b1;
      end else if (en_filt_ff && found) begin
        nxt_bnd       = found_k;
        nxt_stat.sync = 1'b1;
        nxt_stat.hit  = 1'b1;
      end
      // Enable low: boundary held whatever the stream shows
    end else begin
      if (en_rise) begin
        nxt_arm = ARM_SEEK;
      end else if (arm_ff == ARM_SEEK && found) begin
        nxt_bnd       = hit_cur ? bnd_ff : found_k;
        nxt_arm       = ARM_IDLE;
        nxt_stat.sync = 1'b1;
        nxt_stat.hit  = 1'b1;
      end else begin
        nxt_stat.hit = hit_cur;
      end
    end
    if (nxt_bnd >= width) begin
      nxt_bnd = 5'h00;
    end
  end

  // Boundary state clears in reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bnd_ff <= 5'h00;
      arm_ff <= ARM_IDLE;
    end else begin
      bnd_ff <= nxt_bnd;
      arm_ff <= nxt_arm;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------

  // Data and status leave through one stage, so they stay in step
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_data_o     <= 10'h000;
      sync_status_o <= 1'b0;
      pattern_hit_o <= 1'b0;
    end else begin
      rx_data_o     <= f_word(ctrl_ff.width10, strm, nxt_bnd);
      sync_status_o <= nxt_stat.sync;
      pattern_hit_o <= nxt_stat.hit;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addr_take = hsel_i && hready_i && htrans_i[1];
  assign rd_status = addr_take && !hwrite_i && (haddr_i[7:0] == `RXWA_OFS_STATUS)
                     && (haddr_i[31:8] == 24'h000000);

  // Zero wait states; OKAY always
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      ph_act_ff   <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 8'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      ph_act_ff   <= addr_take && hwrite_i && (haddr_i[31:8] == 24'h000000);
      ph_write_ff <= hwrite_i;
      ph_addr_ff  <= haddr_i[7:0];
    end
  end

  // Writes land at the end of the data phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `RXWA_CTRL_RST;
      pat_ff  <= `RXWA_PAT_RST;
      mask_ff <= `RXWA_MASK_RST;
    end else if (ph_act_ff && ph_write_ff) begin
      if (ph_addr_ff == `RXWA_OFS_CTRL) begin
        ctrl_ff <= hwdata_i[2:0];
      end
      if (ph_addr_ff == `RXWA_OFS_PATTERN) begin
        pat_ff <= hwdata_i[15:0];
      end
      if (ph_addr_ff == `RXWA_OFS_MASK) begin
        mask_ff <= hwdata_i[1:0];
      end
    end
  end

  // Read data is latched at the address phase; a write still in its data
  // phase to the same register is forwarded so readback is never stale
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (addr_take && !hwrite_i) begin
      hrdata_o <= 32'h00000000;
      if (haddr_i[31:8] == 24'h000000) begin
        unique case (haddr_i[7:0])
          `RXWA_OFS_CTRL: begin
            hrdata_o[2:0] <= (ph_act_ff && ph_addr_ff == `RXWA_OFS_CTRL) ?
                             hwdata_i[2:0] : ctrl_ff;
          end
          `RXWA_OFS_PATTERN: begin
            hrdata_o[15:0] <= (ph_act_ff && ph_addr_ff == `RXWA_OFS_PATTERN) ?
                              hwdata_i[15:0] : pat_ff;
          end
          `RXWA_OFS_STATUS: begin
            hrdata_o[1:0] <= sticky_ff;
            hrdata_o[`RXWA_ST_BND_LO +: 5] <= bnd_ff;
          end
          `RXWA_OFS_MASK: begin
            hrdata_o[1:0] <= (ph_act_ff && ph_addr_ff == `RXWA_OFS_MASK) ?
                             hwdata_i[1:0] : mask_ff;
          end
          default: begin
            hrdata_o <= 32'h00000000;              // Unmapped reads as zero
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------

  // Read clears; an event in the same cycle survives the clear
  always_comb begin
    nxt_sticky = rd_status ? rxwa_stat_t'(2'h0) : sticky_ff;
    nxt_sticky = nxt_sticky | nxt_stat;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sticky_ff <= '0;
      irq_o     <= 1'b0;
    end else begin
      sticky_ff <= nxt_sticky;
      irq_o     <= |(nxt_sticky & mask_ff);
    end
  end

endmodule : rxwa_top

`default_nettype wire

// >>> hdl/rxwa_params.svh
// Purpose: Offsets, field positions, reset values and widths of the word aligner
// Assumes: Included by bare name by the aligner package users
// Notes:   Definitions only
`ifndef RXWA_PARAMS_SVH
`define RXWA_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RXWA_OFS_CTRL     8'h00
`define RXWA_OFS_PATTERN  8'h04
`define RXWA_OFS_STATUS   8'h08
`define RXWA_OFS_MASK     8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RXWA_CTRL_SLIP    0
`define RXWA_CTRL_W10     1
`define RXWA_CTRL_LEN7    2
`define RXWA_ST_SYNC      0
`define RXWA_ST_HIT       1
`define RXWA_ST_BND_LO    4

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RXWA_CTRL_RST     3'h0
`define RXWA_PAT_RST      16'h017c
`define RXWA_MASK_RST     2'h0
`define RXWA_W8           5'h08
`define RXWA_W10          5'h0a

`endif

// >>> hdl/rxwa_pkg.sv
// Purpose: Types shared by the word aligner design
// Assumes: Constants come from rxwa_params.svh
// Notes:   Types only
package rxwa_pkg;

  // Software control word
  typedef struct packed {
    logic len7;       // 10-bit width: 7-bit pattern
    logic width10;    // 1: 10-bit words, 0: 8-bit words
    logic slip_mode;  // 1: bit-slip, 0: manual alignment
  } rxwa_ctrl_t;

  // Per-cycle status pulses, kept together so they share one stage
  typedef struct packed {
    logic hit;
    logic sync;
  } rxwa_stat_t;

  // Edge-armed search state of the 8-bit manual aligner
  typedef enum logic {
    ARM_IDLE,
    ARM_SEEK
  } rxwa_arm_t;

endpackage : rxwa_pkg

// >>> verification/rxwa_top_sva.sv
// Purpose: Port-level checks of the word aligner
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bus writes are shadowed so mode-dependent checks know the mode
`include "rxwa_params.svh"
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module rxwa_chk
  import rxwa_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [9:0]  rx_word_i,
  input wire logic        align_en_i,
  input wire logic        slip_req_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [9:0]  rx_data_o,
  input wire logic        sync_status_o,
  input wire logic        pattern_hit_o,
  input wire logic        irq_o
);
  logic       wr_ff;
  logic [7:0] ofs_ff;
  logic [2:0] ctrl_ff;
  logic [1:0] mask_ff;
  logic [3:0] age_ff;
  logic [3:0] low_ff;
  logic       en_ff;
  logic       armed_ff;
  // Shadow of CTRL and MASK, taken from the write data phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ff   <= 1'b0;
      ofs_ff  <= 8'h00;
      ctrl_ff <= 3'h0;
      mask_ff <= 2'h0;
    end else begin
      wr_ff  <= hsel_i && hready_i && htrans_i[1] && hwrite_i && (haddr_i[31:8] == 24'h0);
      ofs_ff <= haddr_i[7:0];
      if (wr_ff && ofs_ff == `RXWA_OFS_CTRL) begin
        ctrl_ff <= hwdata_i[2:0];
      end
      if (wr_ff && ofs_ff == `RXWA_OFS_MASK) begin
        mask_ff <= hwdata_i[1:0];
      end
    end
  end
  // Saturating ages: a mode change or enable drop needs time to settle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      age_ff   <= 4'h0;
      low_ff   <= 4'h0;
      en_ff    <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      age_ff   <= (wr_ff && ofs_ff == `RXWA_OFS_CTRL) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
      low_ff   <= align_en_i ? 4'h0 : low_ff + {3'h0, low_ff != 4'hf};
      en_ff    <= align_en_i;
      armed_ff <= (align_en_i && !en_ff) || (armed_ff && !sync_status_o);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sync_with_hit: assert property (sync_status_o |-> pattern_hit_o)
    else $error("sync pulse without hit");
  a_sync_single: assert property (sync_status_o |=> !sync_status_o)
    else $error("sync longer than one cycle");
  a_slip_no_sync: assert property (ctrl_ff[0] && age_ff == 4'hf |-> !sync_status_o)
    else $error("sync in slip mode");
  a_hold_boundary: assert property ((ctrl_ff[1:0] == 2'b10 && age_ff == 4'hf && low_ff == 4'hf)
    |-> !sync_status_o)
    else $error("realign with enable low");
  a_narrow_upper: assert property (!ctrl_ff[1] && age_ff == 4'hf |-> rx_data_o[9:8] == 2'b00)
    else $error("upper bits set in 8-bit mode");
  a_rearm_needed: assert property ((ctrl_ff[1:0] == 2'b00 && age_ff == 4'hf && sync_status_o)
    |-> armed_ff)
    else $error("8-bit realign without enable rise");
  a_reset_quiet: assert property ($rose(rst_n_i) |->
    !sync_status_o && !pattern_hit_o && !irq_o && rx_data_o == 10'h000)
    else $error("outputs not cleared by reset");
  a_irq_follows: assert property (pattern_hit_o && mask_ff[1] |-> ##[0:3] irq_o)
    else $error("unmasked hit raised no interrupt");
  a_bus_okay: assert property (!hresp_o && hreadyout_o)
    else $error("bus slave stalled or answered with an error");
  c_sync: cover property (sync_status_o);
  c_hit_only: cover property (pattern_hit_o && !sync_status_o);
  c_irq: cover property (irq_o);
endmodule : rxwa_chk

bind rxwa_top rxwa_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_word_i(rx_word_i),
  .align_en_i(align_en_i), .slip_req_i(slip_req_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .rx_data_o(rx_data_o), .sync_status_o(sync_status_o), .pattern_hit_o(pattern_hit_o),
  .irq_o(irq_o));
`default_nettype wire

// >>> verification/rxwa_far.sv
// Purpose: Far side: deserializer words plus fabric align and slip control
// Assumes: Patterns are queued only while the bit queue is empty
// Notes:   With nothing queued every word repeats fill_i, with bits 9:8 zeroed for 8-bit words
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Far side model
// ----------------------------------------------------------------
module rxwa_far (
  input  wire logic       clk_i,
  input  wire logic       w10_i,
  input  wire logic [9:0] fill_i,
  output logic      [9:0] rx_word_o,
  output logic            align_en_o,
  output logic            slip_req_o
);
  bit q[$];
  initial begin
    rx_word_o  = 10'h000;
    align_en_o = 1'b0;
    slip_req_o = 1'b0;
  end
  // Oldest stream bit lands in bit 0 of the word
  always @(posedge clk_i) begin : emit
    logic [9:0] w;
    w = fill_i;
    for (int i = 0; i < (w10_i ? 10 : 8); i++) begin
      if (q.size() > 0) begin
        w[i] = q.pop_front();
      end
    end
    rx_word_o <= w10_i ? w : {2'b00, w[7:0]};
  end
  // Pattern after off zero bits, padded to a whole word with zeros
  task automatic put(input logic [15:0] v, input int n, input int off);
    int w;
    w = w10_i ? 10 : 8;
    repeat (off) q.push_back(1'b0);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
    while (q.size() % w != 0) q.push_back(1'b0);
  endtask : put
  // Level held well past the input filter; dropped once aligned
  task automatic set_en(input logic v);
    @(posedge clk_i);
    align_en_o <= v;
    repeat (6) @(posedge clk_i);
  endtask : set_en
  // One clean rising edge per call; the slip test steps eight times, hit or not
  task automatic slip();
    @(posedge clk_i);
    slip_req_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    slip_req_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : slip
endmodule : rxwa_far
`default_nettype wire

// >>> verification/tb_rxwa_top.sv
// Purpose: Self-checking bench of the word aligner
// Assumes: Zero-wait bus slave; boundary read back from STATUS[8:4]
// Notes:   Status pulses are counted as the fabric samples them
`include "rxwa_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_rxwa_top
  import rxwa_pkg::*;
;
  logic        clk_i    = 1'b0;
  logic        rst_n_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic        w10;
  logic [9:0]  fill;
  logic [31:0] hrdata_o, rd;
  logic        hreadyout_o, hresp_o, sync_status_o, pattern_hit_o, irq_o;
  logic        align_en, slip_req;
  logic [9:0]  rx_data_o, rx_word, sync_word;
  int          mismatches = 0, n_compared = 0, n_sync = 0, n_hit = 0;

  always #2.5 clk_i = ~clk_i;
  rxwa_far far (.clk_i(clk_i), .w10_i(w10), .fill_i(fill), .rx_word_o(rx_word),
    .align_en_o(align_en), .slip_req_o(slip_req));
  rxwa_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_word_i(rx_word), .align_en_i(align_en),
    .slip_req_i(slip_req), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_data_o(rx_data_o),
    .sync_status_o(sync_status_o), .pattern_hit_o(pattern_hit_o), .irq_o(irq_o));
  // Pulse counts; the word beside a sync pulse is kept for latency checks
  always @(posedge clk_i) begin
    if (sync_status_o === 1'b1) begin
      n_sync++;
      sync_word = rx_data_o;
    end
    if (pattern_hit_o === 1'b1) n_hit++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // No assumed latency: only the watchdog ends a stalled wait
  task automatic wait_rdy();
    do begin
      @(posedge clk_i);
    end while (hreadyout_o !== 1'b1);
  endtask : wait_rdy
  // Single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata_o;
  endtask : bus
  task automatic emit(input logic [15:0] v, input int n, input int off);
    @(negedge clk_i);
    n_sync = 0;
    n_hit = 0;
    far.put(v, n, off);
    repeat (20) @(posedge clk_i);
  endtask : emit
  task automatic t_regs();
    bus(1'b0, `RXWA_OFS_PATTERN, 32'h0);
    chk(rd, 32'h0000017c);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `RXWA_OFS_MASK, 32'h3);
    bus(1'b0, `RXWA_OFS_MASK, 32'h0);
    chk(rd, 32'h3);
  endtask : t_regs
  task automatic t_man10();
    bus(1'b1, `RXWA_OFS_CTRL, 32'h2);
    w10 <= 1'b1;
    far.set_en(1'b1);
    emit(16'h017c, 10, 3);
    chk(32'(n_sync), 32'h1);
    chk({22'h0, sync_word}, 32'h17c);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b0, `RXWA_OFS_STATUS, 32'h0);
    chk(rd, 32'h33);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    far.set_en(1'b0);
    emit(16'h017c, 10, 5);
    chk(32'(n_sync), 32'h0);
    emit(16'h017c, 10, 3);
    chk({n_sync[15:0], n_hit[15:0]}, 32'h1);
    far.set_en(1'b1);
    emit(16'h0283, 10, 7);
    chk({22'h0, sync_word}, 32'h283);
    bus(1'b0, `RXWA_OFS_STATUS, 32'h0);
    chk({27'h0, rd[8:4]}, 32'h7);
    far.set_en(1'b0);
  endtask : t_man10
  task automatic t_man8();
    bus(1'b1, `RXWA_OFS_CTRL, 32'h0);
    w10 <= 1'b0;
    bus(1'b1, `RXWA_OFS_PATTERN, 32'h0f1e);
    far.set_en(1'b1);
    emit(16'h0f1e, 16, 2);
    chk({n_sync[15:0], 6'h0, sync_word}, 32'h1000f);
    emit(16'h0f1e, 16, 5);
    chk(32'(n_sync), 32'h0);
    far.set_en(1'b0);
    far.set_en(1'b1);
    emit(16'h0f1e, 16, 5);
    bus(1'b0, `RXWA_OFS_STATUS, 32'h0);
    chk({n_sync[15:0], 11'h0, rd[8:4]}, 32'h10005);
    far.set_en(1'b0);
  endtask : t_man8
  task automatic t_slip();
    logic [15:0] exp;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    fill    <= 10'h0f0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({22'h0, rx_data_o}, 32'hf0);
    bus(1'b1, `RXWA_OFS_CTRL, 32'h1);
    bus(1'b1, `RXWA_OFS_PATTERN, 32'h1e1e);
    for (int i = 1; i <= 8; i++) begin
      far.slip();
      @(negedge clk_i);
      n_hit = 0;
      repeat (8) @(posedge clk_i);
      exp = 16'hf0f0 >> (i % 8);
      chk({22'h0, rx_data_o}, {24'h0, exp[7:0]});
      chk({31'h0, n_hit != 0}, {31'h0, exp[7:0] == 8'h1e});
    end
  endtask : t_slip
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Bus idle and reset low from time zero
  initial begin
    rst_n_i  <= 1'b0;
    hsel_i   <= 1'b0;
    haddr_i  <= 32'h0;
    htrans_i <= 2'h0;
    hwrite_i <= 1'b0;
    hsize_i  <= 3'h2;
    hwdata_i <= 32'h0;
    w10      <= 1'b0;
    fill     <= 10'h000;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_man10();
    t_man8();
    t_slip();
    summarize();
  end
  // Whole run needs about four hundred cycles; this cuts a hang short
  initial begin
    repeat (6000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule : tb_rxwa_top
`default_nettype wire
